// File: pkg/t16w_pkg.sv
// Constants and types shared by the 16-bit timer wave-mode control block
package t16w_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] OFF_CTRL_A   = 6'h00;
	localparam logic [5:0] OFF_CTRL_B   = 6'h04;
	localparam logic [5:0] OFF_CMP_A    = 6'h08;
	localparam logic [5:0] OFF_CMP_B    = 6'h0C;
	localparam logic [5:0] OFF_CAPT     = 6'h10;
	localparam logic [5:0] OFF_COUNT    = 6'h14;
	localparam logic [5:0] OFF_IRQ_STAT = 6'h18;
	localparam logic [5:0] OFF_IRQ_CLR  = 6'h1C;
	localparam logic [5:0] OFF_IRQ_EN   = 6'h20;
	localparam logic [5:0] OFF_PIN_DIR  = 6'h24;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         CA_ACT_A_LSB = 6;
	localparam int         CA_ACT_B_LSB = 4;
	localparam logic [7:0] CA_WR_MASK   = 8'hF3;
	localparam int         CB_FILT_BIT  = 7;
	localparam int         CB_MODE_LSB  = 3;
	localparam int         CB_RUN_BIT   = 0;
	localparam logic [7:0] CTRL_A_RST   = 8'h00;
	localparam logic [7:0] CTRL_B_RST   = 8'h00;
	localparam logic [1:0] PIN_DIR_RST  = 2'h0;

	// Interrupt status bit positions
	localparam int IRQ_OVF  = 0;
	localparam int IRQ_MA   = 1;
	localparam int IRQ_MB   = 2;
	localparam int IRQ_CAP  = 3;
	localparam int IRQ_BITS = 4;

	// ----------------------------------------------------------------
	// Counter limits and timing
	// ----------------------------------------------------------------
	localparam logic [15:0] TOP_8BIT  = 16'h00FF;
	localparam logic [15:0] TOP_9BIT  = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] CNT_MAX   = 16'hFFFF;
	localparam logic [15:0] CNT_BOT   = 16'h0000;
	localparam int          FILT_SAMPLES = 4;

	// Waveform family selected by the mode field
	typedef enum logic [2:0] {
		T16W_NONPWM = 3'b000,
		T16W_FAST   = 3'b001,
		T16W_PHASE  = 3'b010,
		T16W_PFC    = 3'b011,
		T16W_RSVD   = 3'b100
	} t16w_class_t;

endpackage

// File: hdl/t16w_capture_filter.sv
// Capture pin synchroniser and optional four-sample noise filter
module t16w_capture_filter (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic capture_pin,
	input  wire logic filter_on,
	output logic      filt_out
);

	logic [2:0] sync_reg;
	logic       level_reg;
	logic [1:0] run_cnt_reg;
	logic       level_next;
	logic       differs;

	// ----------------------------------------------------------------
	// Three-stage synchroniser; stage one feeds only stage two
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_reg  <= 3'h0;
			level_reg <= 1'b0;
		end else begin
			sync_reg  <= {sync_reg[1:0], capture_pin};
			level_reg <= level_next;
		end
	end

	// Level moves only once the two late stages agree
	assign level_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : level_reg;
	assign differs    = level_reg != filt_out;

	// ----------------------------------------------------------------
	// Filter: output follows after four equal samples in a row
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			filt_out    <= 1'b0;
			run_cnt_reg <= 2'h0;
		end else if (!filter_on) begin
			filt_out    <= level_reg;
			run_cnt_reg <= 2'h0;
		end else if (differs &&
			run_cnt_reg == 2'(t16w_pkg::FILT_SAMPLES - 1)) begin
			filt_out    <= level_reg;
			run_cnt_reg <= 2'h0;
		end else begin
			run_cnt_reg <= differs ? 2'(run_cnt_reg + 2'h1) : 2'h0;
		end
	end

	a_filter_four: assert property (@(posedge clk) disable iff (sys_rst)
		filter_on && $changed(filt_out) |->
		$past(level_reg, 1) == $past(level_reg, 4))
		else $error("filter output changed without four equal samples");

endmodule

// File: hdl/t16w_wave_unit.sv
// Waveform output flip-flop of one compare channel
module t16w_wave_unit #(
	parameter bit IS_CHAN_A = 1'b1
) (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire t16w_pkg::t16w_class_t wclass,
	input  wire logic [1:0]            action,
	input  wire logic                  high_bit,
	input  wire logic                  match,
	input  wire logic                  at_top,
	input  wire logic                  count_up,
	input  wire logic                  cmp_is_top,
	output logic                       connected,
	output logic                       wave
);

	logic is_pwm;
	logic do_toggle;
	logic fast_top;
	logic fast_hit;
	logic dual_hit;

	// ----------------------------------------------------------------
	// Decode of the output-action code against the waveform family
	// ----------------------------------------------------------------
	assign is_pwm    = wclass != t16w_pkg::T16W_NONPWM;
	assign connected = action != 2'b00 &&
		!(is_pwm && action == 2'b01 && !(high_bit && IS_CHAN_A));
	assign do_toggle = match && connected && action == 2'b01;
	assign fast_top  = wclass == t16w_pkg::T16W_FAST && at_top && action[1];
	// Compare equal to top is ignored; the top action alone applies
	assign fast_hit  = wclass == t16w_pkg::T16W_FAST && match &&
		action[1] && !cmp_is_top;
	assign dual_hit  = (wclass == t16w_pkg::T16W_PHASE ||
		wclass == t16w_pkg::T16W_PFC) && match && action[1];

	// ----------------------------------------------------------------
	// Output register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wave <= 1'b0;
		end else if (do_toggle) begin
			wave <= !wave;
		end else if (!is_pwm && match && action[1]) begin
			wave <= action[0];
		end else if (fast_top) begin
			wave <= !action[0];
		end else if (fast_hit) begin
			wave <= action[0];
		end else if (dual_hit) begin
			wave <= count_up ? action[0] : !action[0];
		end
	end

	a_fast_top: assert property (@(posedge clk) disable iff (sys_rst)
		fast_top |=> wave == !$past(action[0]))
		else $error("fast mode top action wrong");

	a_dual_match: assert property (@(posedge clk) disable iff (sys_rst)
		dual_hit && !do_toggle |=> wave == ($past(count_up) ~^ $past(action[0])))
		else $error("dual slope match action wrong");

endmodule

// File: hdl/t16w_wave_ctrl.sv
// Top of the 16-bit timer wave-mode control block with Avalon-MM registers
//
// Notes on behaviour
// - Nonzero action field hands pin to waveform; driver needs direction bit.
// - Non-PWM codes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clears on match, sets at top; 11 the reverse.
// - PWM code 01: off unless high mode bit; then A toggles, B reserved.
// - Fast PWM with compare equal top: ignore match, only act at top.
// - Dual slope: 10 clears on up match, sets on down; 11 reversed.
// - Mode field from ctrl A bits 1:0 and ctrl B pair; 13 reserved.
// - Modes 0,4,12: tops max, compare A, capture; immediate update; flag at max.
// - Modes 1-3,10,11 phase correct; update at top; flag at bottom.
// - Modes 5-7,14,15 fast PWM; update at top; flag at top.
// - Modes 8,9 take capture or compare A top; update and flag at bottom.
// - Filter on: capture level changes after four equal samples.
// - Dual slope counts bottom to top and back, top held one cycle.
module t16w_wave_ctrl (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        capture_pin,
	input  wire logic        port_data_a,
	input  wire logic        port_data_b,
	output logic             wave_out_a,
	output logic             wave_out_a_oe,
	output logic             wave_out_b,
	output logic             wave_out_b_oe,
	output logic             irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]          ctrl_a_reg;
	logic [7:0]          ctrl_b_reg;
	logic [15:0]         cmp_a_buf_reg;
	logic [15:0]         cmp_b_buf_reg;
	logic [15:0]         cmp_a_reg;
	logic [15:0]         cmp_b_reg;
	logic [15:0]         capt_reg;
	logic [15:0]         count_reg;
	logic [15:0]         count_next;
	logic                dir_up_reg;
	logic                dir_up_next;
	logic [3:0]          irq_stat_reg;
	logic [3:0]          irq_stat_next;
	logic [3:0]          irq_en_reg;
	logic [1:0]          pin_dir_reg;
	logic                capt_prev_reg;
	logic [31:0]         rd_mux;
	logic [3:0]          mode;
	t16w_pkg::t16w_class_t wclass;
	logic [15:0]         top_w;
	logic                top_capt;
	logic                tick;
	logic                at_top;
	logic                at_bot;
	logic                is_dual;
	logic                upd_cmp;
	logic                ovf_set;
	logic                match_a;
	logic                match_b;
	logic                capt_evt;
	logic                filt_level;
	logic                conn_a;
	logic                conn_b;
	logic                wave_a;
	logic                wave_b;
	logic                wr_hit;
	logic [3:0]          irq_set;
	logic [3:0]          irq_clr;

	// Decode of waveform family from the mode number
	function automatic t16w_pkg::t16w_class_t class_of(input logic [3:0] m);
		unique case (m)
			4'h0, 4'h4, 4'hC: class_of = t16w_pkg::T16W_NONPWM;
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF: class_of = t16w_pkg::T16W_FAST;
			4'h1, 4'h2, 4'h3, 4'hA, 4'hB: class_of = t16w_pkg::T16W_PHASE;
			4'h8, 4'h9: class_of = t16w_pkg::T16W_PFC;
			4'hD: class_of = t16w_pkg::T16W_RSVD;
		endcase
	endfunction

	// Byte-lane merge for the 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] be);
		merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	// ----------------------------------------------------------------
	// Mode decode, top source and counter events
	// ----------------------------------------------------------------
	assign mode     = {ctrl_b_reg[t16w_pkg::CB_MODE_LSB +: 2],
		ctrl_a_reg[1:0]};
	assign wclass   = class_of(mode);
	assign top_capt = mode == 4'h8 || mode == 4'hA || mode == 4'hC ||
		mode == 4'hE;
	assign top_w    = (mode == 4'h1 || mode == 4'h5) ? t16w_pkg::TOP_8BIT :
		(mode == 4'h2 || mode == 4'h6) ? t16w_pkg::TOP_9BIT :
		(mode == 4'h3 || mode == 4'h7) ? t16w_pkg::TOP_10BIT :
		top_capt ? capt_reg :
		(mode == 4'h4 || mode == 4'h9 || mode == 4'hB || mode == 4'hF) ?
		cmp_a_reg : t16w_pkg::CNT_MAX;
	// Reserved mode stops the counter rather than guessing a sequence
	assign tick     = ctrl_b_reg[t16w_pkg::CB_RUN_BIT] &&
		wclass != t16w_pkg::T16W_RSVD;
	assign is_dual  = wclass == t16w_pkg::T16W_PHASE ||
		wclass == t16w_pkg::T16W_PFC;
	assign at_top   = tick && count_reg == top_w;
	assign at_bot   = tick && count_reg == t16w_pkg::CNT_BOT && !dir_up_reg;
	assign match_a  = tick && count_reg == cmp_a_reg;
	assign match_b  = tick && count_reg == cmp_b_reg;
	assign upd_cmp  = (wclass == t16w_pkg::T16W_NONPWM) ||
		(wclass == t16w_pkg::T16W_PFC ? at_bot :
		(wclass != t16w_pkg::T16W_RSVD && at_top));
	assign ovf_set  = wclass == t16w_pkg::T16W_NONPWM ?
		(tick && count_reg == t16w_pkg::CNT_MAX) :
		wclass == t16w_pkg::T16W_FAST ? at_top :
		is_dual && at_bot;

	// Next count: single slope wraps at top, dual slope turns round
	assign count_next = !tick ? count_reg :
		is_dual ? (dir_up_reg ?
			(at_top ? 16'(count_reg - 16'h0001) : 16'(count_reg + 16'h0001)) :
			(at_bot ? 16'(count_reg + 16'h0001) :
				16'(count_reg - 16'h0001))) :
		at_top ? t16w_pkg::CNT_BOT : 16'(count_reg + 16'h0001);
	assign dir_up_next = !is_dual ? 1'b1 :
		(dir_up_reg && at_top) ? 1'b0 : at_bot ? 1'b1 : dir_up_reg;

	// ----------------------------------------------------------------
	// Capture path
	// ----------------------------------------------------------------
	t16w_capture_filter u_filter (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.capture_pin (capture_pin),
		.filter_on   (ctrl_b_reg[t16w_pkg::CB_FILT_BIT]),
		.filt_out    (filt_level)
	);

	// Rising edge captures; pin is ignored while capture sets the top
	assign capt_evt = filt_level && !capt_prev_reg && !top_capt;

	// ----------------------------------------------------------------
	// Register bus decode and interrupt status
	// ----------------------------------------------------------------
	// One wait cycle: request seen with wait high, served with wait low
	assign wr_hit  = avs_write && !avs_waitrequest;
	assign irq_clr = (wr_hit && avs_address == t16w_pkg::OFF_IRQ_CLR &&
		avs_byteenable[0]) ? avs_writedata[3:0] : 4'h0;
	assign irq_set = {capt_evt || (top_capt && at_top), match_b, match_a,
		ovf_set};
	// Set wins over a clear in the same cycle
	assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
	assign rd_mux  =
		avs_address == t16w_pkg::OFF_CTRL_A ?
			{24'h0, ctrl_a_reg & t16w_pkg::CA_WR_MASK} :
		avs_address == t16w_pkg::OFF_CTRL_B ? {24'h0, ctrl_b_reg} :
		avs_address == t16w_pkg::OFF_CMP_A ? {16'h0, cmp_a_buf_reg} :
		avs_address == t16w_pkg::OFF_CMP_B ? {16'h0, cmp_b_buf_reg} :
		avs_address == t16w_pkg::OFF_CAPT ? {16'h0, capt_reg} :
		avs_address == t16w_pkg::OFF_COUNT ? {16'h0, count_reg} :
		avs_address == t16w_pkg::OFF_IRQ_STAT ? {28'h0, irq_stat_reg} :
		avs_address == t16w_pkg::OFF_IRQ_EN ? {28'h0, irq_en_reg} :
		avs_address == t16w_pkg::OFF_PIN_DIR ? {30'h0, pin_dir_reg} :
		32'h0000_0000;

	// Bus handshake and read data
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if (avs_waitrequest && (avs_read || avs_write)) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= rd_mux;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Control registers written by software
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_a_reg    <= t16w_pkg::CTRL_A_RST;
			ctrl_b_reg    <= t16w_pkg::CTRL_B_RST;
			irq_en_reg    <= 4'h0;
			pin_dir_reg   <= t16w_pkg::PIN_DIR_RST;
			cmp_a_buf_reg <= 16'h0000;
			cmp_b_buf_reg <= 16'h0000;
		end else if (wr_hit && avs_byteenable[0]) begin
			if (avs_address == t16w_pkg::OFF_CTRL_A)
				ctrl_a_reg <= avs_writedata[7:0] & t16w_pkg::CA_WR_MASK;
			if (avs_address == t16w_pkg::OFF_CTRL_B)
				ctrl_b_reg <= avs_writedata[7:0];
			if (avs_address == t16w_pkg::OFF_IRQ_EN)
				irq_en_reg <= avs_writedata[3:0];
			if (avs_address == t16w_pkg::OFF_PIN_DIR)
				pin_dir_reg <= avs_writedata[1:0];
			if (avs_address == t16w_pkg::OFF_CMP_A)
				cmp_a_buf_reg <= merge16(cmp_a_buf_reg, avs_writedata,
					avs_byteenable);
			if (avs_address == t16w_pkg::OFF_CMP_B)
				cmp_b_buf_reg <= merge16(cmp_b_buf_reg, avs_writedata,
					avs_byteenable);
		end
	end

	// Counter, compare registers, capture and status
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg     <= t16w_pkg::CNT_BOT;
			dir_up_reg    <= 1'b1;
			cmp_a_reg     <= 16'h0000;
			cmp_b_reg     <= 16'h0000;
			capt_reg      <= 16'h0000;
			capt_prev_reg <= 1'b0;
			irq_stat_reg  <= 4'h0;
		end else begin
			count_reg     <= (wr_hit && avs_address == t16w_pkg::OFF_COUNT) ?
				merge16(count_reg, avs_writedata, avs_byteenable) : count_next;
			dir_up_reg    <= dir_up_next;
			capt_prev_reg <= filt_level;
			irq_stat_reg  <= irq_stat_next;
			if (upd_cmp) begin
				cmp_a_reg <= cmp_a_buf_reg;
				cmp_b_reg <= cmp_b_buf_reg;
			end
			if (wr_hit && avs_address == t16w_pkg::OFF_CAPT)
				capt_reg <= merge16(capt_reg, avs_writedata, avs_byteenable);
			else if (capt_evt)
				capt_reg <= count_reg;
		end
	end

	// ----------------------------------------------------------------
	// Waveform units and pin drivers
	// ----------------------------------------------------------------
	t16w_wave_unit #(.IS_CHAN_A(1'b1)) u_wave_a (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.wclass     (wclass),
		.action     (ctrl_a_reg[t16w_pkg::CA_ACT_A_LSB +: 2]),
		.high_bit   (mode[3]),
		.match      (match_a),
		.at_top     (at_top),
		.count_up   (dir_up_reg),
		.cmp_is_top (cmp_a_reg == top_w),
		.connected  (conn_a),
		.wave       (wave_a)
	);

	t16w_wave_unit #(.IS_CHAN_A(1'b0)) u_wave_b (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.wclass     (wclass),
		.action     (ctrl_a_reg[t16w_pkg::CA_ACT_B_LSB +: 2]),
		.high_bit   (mode[3]),
		.match      (match_b),
		.at_top     (at_top),
		.count_up   (dir_up_reg),
		.cmp_is_top (cmp_b_reg == top_w),
		.connected  (conn_b),
		.wave       (wave_b)
	);

	// Pins are registered so every output comes from a flip-flop
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wave_out_a    <= 1'b0;
			wave_out_b    <= 1'b0;
			wave_out_a_oe <= 1'b0;
			wave_out_b_oe <= 1'b0;
			irq           <= 1'b0;
		end else begin
			wave_out_a    <= conn_a ? wave_a : port_data_a;
			wave_out_b    <= conn_b ? wave_b : port_data_b;
			wave_out_a_oe <= pin_dir_reg[0];
			wave_out_b_oe <= pin_dir_reg[1];
			irq           <= |(irq_stat_next & irq_en_reg);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_resv_zero: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl_a_reg[3:2] == 2'b00)
		else $error("reserved control bits not zero");

	a_ctc_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		mode == 4'h4 && at_top && !wr_hit |=> count_reg == 16'h0000)
		else $error("clear-on-match did not wrap");

	a_top_once: assert property (@(posedge clk) disable iff (sys_rst)
		is_dual && at_top && dir_up_reg && !wr_hit |=>
		count_reg == 16'($past(count_reg) - 16'h0001) && !dir_up_reg)
		else $error("dual slope top not held exactly once");

	a_ovf_bot: assert property (@(posedge clk) disable iff (sys_rst)
		is_dual && at_bot |=> irq_stat_reg[t16w_pkg::IRQ_OVF])
		else $error("overflow not set at bottom");

	a_ovf_top: assert property (@(posedge clk) disable iff (sys_rst)
		wclass == t16w_pkg::T16W_FAST && at_top |=>
		irq_stat_reg[t16w_pkg::IRQ_OVF])
		else $error("overflow not set at top");

	a_fixed_top: assert property (@(posedge clk) disable iff (sys_rst)
		mode == 4'h2 |-> top_w == 16'h01FF)
		else $error("fixed top wrong");

	a_buf_hold: assert property (@(posedge clk) disable iff (sys_rst)
		wclass == t16w_pkg::T16W_PFC && !at_bot |=> $stable(cmp_a_reg))
		else $error("compare reloaded away from bottom");

	a_pin_oe: assert property (@(posedge clk) disable iff (sys_rst)
		##1 wave_out_a_oe == $past(pin_dir_reg[0]) &&
		(wave_out_a == ($past(conn_a) ? $past(wave_a) : $past(port_data_a))))
		else $error("pin driver does not follow direction");

endmodule

// File: verification/tb.sv
// Self-checking testbench for the 16-bit timer wave-mode control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Stimulus signals and bench state
	// ----------------------------------------------------------------
	logic        clk             = 1'b0;
	logic        sys_rst         = 1'b1;
	logic [5:0]  avs_address     = 6'h00;
	logic        avs_read        = 1'b0;
	logic        avs_write       = 1'b0;
	logic [31:0] avs_writedata   = 32'h00000000;
	logic [3:0]  avs_byteenable  = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        capture_pin     = 1'b0;
	logic        port_data_a     = 1'b0;
	logic        port_data_b     = 1'b0;
	logic        wave_out_a;
	logic        wave_out_a_oe;
	logic        wave_out_b;
	logic        wave_out_b_oe;
	logic        irq;
	logic [31:0] rdv;
	int          miscompares     = 0;
	int          checks          = 0;
	int          h;
	int          hb;
	// Mode sweep: mode and its top; register tops stay at 0x30
	int mt[15]   = '{1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 14, 15, 4, 12, 13};
	int mtop[15] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h00FF, 16'h01FF,
		16'h03FF, 16'h0030, 16'h0030, 16'h0030, 16'h0030, 16'h0030,
		16'h0030, 16'h0030, 16'h0030, 16'h0000};
	// Duty model: mode, compare, action, window, high cycles (-1 = port)
	int dm[11]   = '{4, 4, 4, 4, 5, 5, 5, 5, 15, 1, 1};
	int dc[11]   = '{16'h0020, 16'h0020, 16'h0020, 16'h0020, 16'h0040,
		16'h0040, 16'h00FF, 16'h0040, 16'h0040, 16'h0040, 16'h0040};
	int da[11]   = '{3, 2, 1, 0, 2, 3, 2, 1, 1, 2, 3};
	int dw[11]   = '{66, 66, 66, 66, 256, 256, 256, 256, 130, 510, 510};
	int de[11]   = '{66, 0, 33, -1, 65, 191, 256, -1, 65, 128, 382};
	// Channel B mirrors A, but code 01 with the high mode bit is reserved
	int dbe[11]  = '{66, 0, 33, -1, 65, 191, 256, -1, -1, 128, 382};

	always #4 clk = ~clk;

	t16w_wave_ctrl dut (.clk(clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .capture_pin(capture_pin),
		.port_data_a(port_data_a), .port_data_b(port_data_b),
		.wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
		.wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe), .irq(irq));

	// ----------------------------------------------------------------
	// Bus, compare and closing tasks
	// ----------------------------------------------------------------
	// Holds the request until waitrequest is seen low, then one idle edge
	task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rdv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Pin counts carry a few cycles of pipeline slack
	task automatic chk_near(input string n, input int e, input int g);
		checks++;
		if (g < e - 3 || g > e + 3) begin
			miscompares++;
			$display("[FAIL] %s expected %0d seen %0d", n, e, g);
		end
	endtask

	task automatic setup(input int m, input int act, input logic [15:0] c);
		bus(1'b1, t16w_pkg::OFF_CTRL_B, {27'h0, m[3:2], 3'h0});
		bus(1'b1, t16w_pkg::OFF_COUNT, 32'h0);
		bus(1'b1, t16w_pkg::OFF_CMP_A, {16'h0, c});
		bus(1'b1, t16w_pkg::OFF_CMP_B, {16'h0, c});
		bus(1'b1, t16w_pkg::OFF_CAPT, {16'h0, c});
		bus(1'b1, t16w_pkg::OFF_IRQ_CLR, 32'hF);
		bus(1'b1, t16w_pkg::OFF_CTRL_A,
			{24'h0, act[1:0], act[1:0], 2'h0, m[1:0]});
		bus(1'b1, t16w_pkg::OFF_CTRL_B, {27'h0, m[3:2], 3'h1});
	endtask

	// A pulse of n samples, then time for sync and filter to settle
	task automatic pulse(input int n);
		capture_pin <= 1'b1;
		repeat (n) @(posedge clk);
		capture_pin <= 1'b0;
		repeat (12) @(posedge clk);
		bus(1'b0, t16w_pkg::OFF_IRQ_STAT, 32'h0);
	endtask

	task automatic test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(1));
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, t16w_pkg::OFF_CTRL_A, 32'h0);
		chk("ctrl_a_rst", {24'h0, t16w_pkg::CTRL_A_RST}, rdv);
		bus(1'b1, t16w_pkg::OFF_CTRL_A, 32'hFF);
		bus(1'b0, t16w_pkg::OFF_CTRL_A, 32'h0);
		chk("ctrl_a_rsvd", 32'hF3, rdv);
		bus(1'b0, 6'h28, 32'h0);
		chk("unmapped", 32'h0, rdv);
		bus(1'b1, t16w_pkg::OFF_PIN_DIR, 32'h1);
		repeat (2) @(posedge clk);
		chk("oe_a", 32'h1, {31'h0, wave_out_a_oe});
		chk("oe_b", 32'h0, {31'h0, wave_out_b_oe});
		// Flag position and count range per mode; 4, 12 never reach max
		foreach (mt[i]) begin
			setup(mt[i], 0, mtop[i][15:0]);
			repeat (2 * mtop[i] + 20) @(posedge clk);
			bus(1'b0, t16w_pkg::OFF_IRQ_STAT, 32'h0);
			chk("ovf_flag", {31'h0, !(mt[i] inside {4, 12, 13})},
				{31'h0, rdv[t16w_pkg::IRQ_OVF]});
			repeat (4) begin
				repeat ($urandom_range(9)) @(posedge clk);
				bus(1'b0, t16w_pkg::OFF_COUNT, 32'h0);
				chk("count_le_top", 32'h1, {31'h0, rdv <= mtop[i]});
			end
		end
		// High time of both channels over one warm window, then one counted
		foreach (dm[i]) begin
			port_data_a <= 1'($urandom);
			port_data_b <= 1'($urandom);
			setup(dm[i], da[i], dc[i][15:0]);
			repeat (dw[i]) @(posedge clk);
			h = 0;
			hb = 0;
			repeat (dw[i]) begin
				@(posedge clk);
				h += (wave_out_a === 1'b1);
				hb += (wave_out_b === 1'b1);
			end
			chk_near("duty_a", de[i] < 0 ? ((port_data_a === 1'b1) ? dw[i] : 0)
				: de[i], h);
			chk_near("duty_b", dbe[i] < 0 ?
				((port_data_b === 1'b1) ? dw[i] : 0) : dbe[i],
				hb);
		end
		// Interrupt: enable, mask, clear; the match A status bit must stay
		setup(5, 0, 16'h0040);
		repeat (300) @(posedge clk);
		bus(1'b1, t16w_pkg::OFF_CTRL_B, {27'h0, 2'h1, 3'h0});
		bus(1'b1, t16w_pkg::OFF_IRQ_EN, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq_on", 32'h1, {31'h0, irq});
		bus(1'b1, t16w_pkg::OFF_IRQ_EN, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq_masked", 32'h0, {31'h0, irq});
		bus(1'b1, t16w_pkg::OFF_IRQ_EN, 32'h1);
		bus(1'b1, t16w_pkg::OFF_IRQ_CLR, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq_clr", 32'h0, {31'h0, irq});
		bus(1'b0, t16w_pkg::OFF_IRQ_STAT, 32'h0);
		chk("stat_keep", 32'h2, rdv & 32'h3);
		// Capture filter: three equal samples are not enough, more are
		setup(0, 0, 16'h0000);
		bus(1'b1, t16w_pkg::OFF_CTRL_B, 32'h81);
		pulse(3);
		chk("cap_filt_short", 32'h0, {31'h0, rdv[t16w_pkg::IRQ_CAP]});
		pulse(10);
		chk("cap_filt_long", 32'h1, {31'h0, rdv[t16w_pkg::IRQ_CAP]});
		bus(1'b1, t16w_pkg::OFF_IRQ_CLR, 32'h8);
		bus(1'b1, t16w_pkg::OFF_CTRL_B, 32'h01);
		pulse(3);
		chk("cap_nofilt", 32'h1, {31'h0, rdv[t16w_pkg::IRQ_CAP]});
		// Normal mode flags overflow only when the count passes its maximum
		bus(1'b1, t16w_pkg::OFF_COUNT, 32'hFFF0);
		repeat (20) @(posedge clk);
		bus(1'b0, t16w_pkg::OFF_IRQ_STAT, 32'h0);
		chk("ovf_max", 32'h1, {31'h0, rdv[t16w_pkg::IRQ_OVF]});
		test_done();
	end

	// Watchdog sized well above the expected run of about 15000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		test_done();
	end
endmodule
